// ===== rtl/ea_gen_pkg.sv
package ea_gen_pkg;
    // *****************************************************
    // widths and constants
    // *****************************************************
    localparam int ADDR_W = 16;
    localparam int ACC_W = 36;
    localparam int SHORT_W = 6;
    localparam int IMM7_W = 7;
    localparam logic [15:0] MOD_LINEAR = 16'hffff;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] OFS_RESET = 16'h0000;
    localparam logic [1:0] EXTRA_NONE = 2'h0;
    localparam logic [1:0] EXTRA_ONE = 2'h1;
    localparam logic [1:0] EXTRA_TWO = 2'h2;

    // *****************************************************
    // addressing modes
    // *****************************************************
    typedef enum logic [3:0] {
        MODE_NO_UPDATE = 4'h0,
        MODE_POST_INC = 4'h1,
        MODE_POST_DEC = 4'h2,
        MODE_POST_OFS = 4'h3,
        MODE_INDEX_OFS = 4'h4,
        MODE_SHORT_DISP = 4'h5,
        MODE_LONG_DISP = 4'h6,
        MODE_IMM_LONG = 4'h7,
        MODE_IMM_SHORT_U = 4'h8,
        MODE_IMM_SHORT_S = 4'h9,
        MODE_ABS_LONG = 4'ha,
        MODE_ABS_SHORT = 4'hb,
        MODE_IO_SHORT = 4'hc
    } ea_mode_e;

    // pointer select: 0..3 pointers, 4 stack pointer
    typedef enum logic [2:0] {
        SEL_PTR0 = 3'h0,
        SEL_PTR1 = 3'h1,
        SEL_PTR2 = 3'h2,
        SEL_PTR3 = 3'h3,
        SEL_SP = 3'h4
    } ptr_sel_e;
endpackage : ea_gen_pkg

// ===== rtl/effective_address_generation.sv
`timescale 1ns/100ps
// Functional notes
// R1: no-update mode uses pointer as address, pointer unchanged, no extra cost.
// R2: post-increment accesses at pointer, then writes pointer plus one.
// R3: modifier selects linear or modulo for pointers zero/one; others linear.
// R4: post-decrement accesses at pointer, then writes pointer minus one.
// R5: post-offset accesses at pointer, then adds signed offset into pointer.
// R6: index-by-offset address is pointer plus offset, one extra cycle.
// R7: short displacement: one-extend for stack pointer, zero-extend for pointer two.
// R8: short displacement always linear, one extra cycle, no extra words.
// R9: long displacement adds signed extension word, two extra cycles.
// R10: long immediate from extension word, program reference, one extra cycle.
// R11: short immediates: unsigned 6-bit for loops, signed 7-bit for moves.
// R12: absolute long uses extension word unmodified as address.
// R13: absolute short zero-extends 6 bits, lowest 64 locations.
// R14: I/O short one-extends 6 bits, top 64 locations.
// R15: software uses other modes for peripherals outside the top range.
// R16: all-ones modifier selects linear; modifier resets to all ones.
// R17: pointer is one of four pointer registers or the stack pointer.
// R18: long immediate to accumulator: middle load, sign extend, clear low.
// R19: linear arithmetic is 16-bit and wraps silently.
module effective_address_generation
    import ea_gen_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // decoded request
    input wire logic req_valid_in,
    input wire ea_gen_pkg::ea_mode_e mode_in,
    input wire ea_gen_pkg::ptr_sel_e ptr_sel_in,
    input wire logic [15:0] op_word_in,
    input wire logic [15:0] ext_word_in,
    // register writes from the core
    input wire logic reg_wr_in,
    input wire ea_gen_pkg::ptr_sel_e reg_wr_sel_in,
    input wire logic reg_wr_ofs_in,
    input wire logic reg_wr_mod_in,
    input wire logic [15:0] reg_wr_data_in,
    // results
    output logic ea_valid_out,
    output logic [15:0] ea_addr_out,
    output logic xmem_ref_out,
    output logic pmem_ref_out,
    output logic ext_word_used_out,
    output logic [1:0] extra_cycles_out,
    output logic [15:0] imm_data_out,
    output logic [35:0] acc_imm_out,
    output logic modulo_req_out,
    // register views
    output logic [15:0] ptr0_out,
    output logic [15:0] ptr1_out,
    output logic [15:0] ptr2_out,
    output logic [15:0] ptr3_out,
    output logic [15:0] sp_out,
    output logic [15:0] ofs_out,
    output logic [15:0] mod_out
);
    // *****************************************************
    // state
    // *****************************************************
    logic [15:0] ptr_ff [0:4];
    logic [15:0] ofs_ff;
    logic [15:0] mod_ff;
    logic [15:0] cur_ptr;
    logic [15:0] nxt_addr;
    logic [15:0] nxt_ptr;
    logic ptr_upd;
    logic use_mod;
    logic xref;
    logic pref;
    logic extw;
    logic [1:0] extra;

    // 16-bit wrapping add
    function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        // R19 wrap silently
        return s[15:0];
    endfunction : add16

    // R17 pointer select
    assign cur_ptr = ptr_ff[ptr_sel_in];

    // R3 modulo only possible on pointers zero and one
    // R16 all-ones means linear
    assign use_mod = (ptr_sel_in == SEL_PTR0 || ptr_sel_in == SEL_PTR1) && (mod_ff != MOD_LINEAR);

    // address and update decode
    always_comb begin
        nxt_addr = cur_ptr;
        nxt_ptr = cur_ptr;
        ptr_upd = 1'b0;
        xref = 1'b1;
        pref = 1'b0;
        extw = 1'b0;
        extra = EXTRA_NONE;
        case (mode_in)
            // R1 no update
            MODE_NO_UPDATE: begin
                nxt_addr = cur_ptr;
            end
            // R2 post increment
            MODE_POST_INC: begin
                nxt_ptr = add16(cur_ptr, 16'h0001);
                ptr_upd = 1'b1;
            end
            // R4 post decrement
            MODE_POST_DEC: begin
                nxt_ptr = add16(cur_ptr, 16'hffff);
                ptr_upd = 1'b1;
            end
            // R5 post update by offset
            MODE_POST_OFS: begin
                nxt_ptr = add16(cur_ptr, ofs_ff);
                ptr_upd = 1'b1;
            end
            // R6 index by offset
            MODE_INDEX_OFS: begin
                nxt_addr = add16(cur_ptr, ofs_ff);
                extra = EXTRA_ONE;
            end
            // R7 short displacement extension
            // R8 linear, one extra cycle
            MODE_SHORT_DISP: begin
                if (ptr_sel_in == SEL_SP) begin
                    nxt_addr = add16(cur_ptr, {10'h3ff, op_word_in[5:0]});
                end else begin
                    nxt_addr = add16(cur_ptr, {10'h000, op_word_in[5:0]});
                end
                extra = EXTRA_ONE;
            end
            // R9 long displacement
            MODE_LONG_DISP: begin
                nxt_addr = add16(cur_ptr, ext_word_in);
                extw = 1'b1;
                extra = EXTRA_TWO;
            end
            // R10 long immediate
            MODE_IMM_LONG: begin
                xref = 1'b0;
                pref = 1'b1;
                extw = 1'b1;
                extra = EXTRA_ONE;
                nxt_addr = 16'h0000;
            end
            // R11 short immediates
            MODE_IMM_SHORT_U, MODE_IMM_SHORT_S: begin
                xref = 1'b0;
                pref = 1'b1;
                nxt_addr = 16'h0000;
            end
            // R12 absolute long
            MODE_ABS_LONG: begin
                nxt_addr = ext_word_in;
                pref = 1'b1;
                extw = 1'b1;
            end
            // R13 absolute short
            MODE_ABS_SHORT: begin
                nxt_addr = {10'h000, op_word_in[5:0]};
            end
            // R14 I/O short
            MODE_IO_SHORT: begin
                nxt_addr = {10'h3ff, op_word_in[5:0]};
            end
            default: begin
                xref = 1'b0;
            end
        endcase
    end

    // *****************************************************
    // pointer file
    // *****************************************************
    // pointer update after access, core writes otherwise
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 5; i++) begin
                ptr_ff[i] <= PTR_RESET;
            end
        end else if (req_valid_in && ptr_upd) begin
            ptr_ff[ptr_sel_in] <= nxt_ptr;
        end else if (reg_wr_in && !reg_wr_ofs_in && !reg_wr_mod_in) begin
            ptr_ff[reg_wr_sel_in] <= reg_wr_data_in;
        end
    end

    // offset register: never changed by addressing
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ofs_ff <= OFS_RESET;
        end else if (reg_wr_in && reg_wr_ofs_in) begin
            ofs_ff <= reg_wr_data_in;
        end
    end

    // R16 modifier resets to linear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mod_ff <= MOD_LINEAR;
        end else if (reg_wr_in && reg_wr_mod_in && !reg_wr_ofs_in) begin
            mod_ff <= reg_wr_data_in;
        end
    end

    // *****************************************************
    // result registers
    // *****************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ea_valid_out <= 1'b0;
            ea_addr_out <= 16'h0000;
            xmem_ref_out <= 1'b0;
            pmem_ref_out <= 1'b0;
            ext_word_used_out <= 1'b0;
            extra_cycles_out <= EXTRA_NONE;
            imm_data_out <= 16'h0000;
            acc_imm_out <= 36'h000000000;
            modulo_req_out <= 1'b0;
        end else begin
            ea_valid_out <= req_valid_in;
            if (req_valid_in) begin
                ea_addr_out <= nxt_addr;
                xmem_ref_out <= xref;
                pmem_ref_out <= pref;
                ext_word_used_out <= extw;
                extra_cycles_out <= extra;
                // R3 modulo flag for the modulo unit, never for short displacement
                modulo_req_out <= use_mod && (mode_in == MODE_POST_INC ||
                    mode_in == MODE_POST_DEC || mode_in == MODE_POST_OFS ||
                    mode_in == MODE_INDEX_OFS || mode_in == MODE_LONG_DISP);
                // R11 short immediate extension
                if (mode_in == MODE_IMM_SHORT_U) begin
                    imm_data_out <= {10'h000, op_word_in[5:0]};
                end else if (mode_in == MODE_IMM_SHORT_S) begin
                    imm_data_out <= {{9{op_word_in[6]}}, op_word_in[6:0]};
                end else begin
                    imm_data_out <= ext_word_in;
                end
                // R18 accumulator image of long immediate
                acc_imm_out <= {{4{ext_word_in[15]}}, ext_word_in, 16'h0000};
            end
        end
    end

    // register views
    assign ptr0_out = ptr_ff[SEL_PTR0];
    assign ptr1_out = ptr_ff[SEL_PTR1];
    assign ptr2_out = ptr_ff[SEL_PTR2];
    assign ptr3_out = ptr_ff[SEL_PTR3];
    assign sp_out = ptr_ff[SEL_SP];
    assign ofs_out = ofs_ff;
    assign mod_out = mod_ff;

    // *****************************************************
    // assertions
    // *****************************************************
    a_post_inc_ptr: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
        req_valid_in && mode_in == MODE_POST_INC |=>
        ptr_ff[$past(ptr_sel_in)] == $past(cur_ptr) + 16'h0001
        && ea_addr_out == $past(cur_ptr)) else $error("post increment wrong");
    a_post_dec_ptr: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
        req_valid_in && mode_in == MODE_POST_DEC |=>
        ptr_ff[$past(ptr_sel_in)] == $past(cur_ptr) - 16'h0001) else $error("post decrement wrong");
    a_no_update_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
        req_valid_in && mode_in == MODE_NO_UPDATE && !reg_wr_in |=>
        ptr_ff[$past(ptr_sel_in)] == $past(cur_ptr) && ea_addr_out == $past(cur_ptr)
        && extra_cycles_out == 2'h0 && !ext_word_used_out)
        else $error("no update changed pointer");
    a_index_ofs_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        req_valid_in && mode_in == MODE_INDEX_OFS |=>
        ea_addr_out == $past(cur_ptr) + $past(ofs_ff) && extra_cycles_out == 2'h1)
        else $error("index by offset wrong");
    a_short_sp_neg: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
        req_valid_in && mode_in == MODE_SHORT_DISP && ptr_sel_in == SEL_SP |=>
        ea_addr_out == $past(cur_ptr) + {10'h3ff, $past(op_word_in[5:0])})
        else $error("short displacement wrong");
    a_long_disp_cyc: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
        req_valid_in && mode_in == MODE_LONG_DISP |=>
        extra_cycles_out == 2'h2 && ext_word_used_out) else $error("long displacement cost");
    a_io_short_top: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R14
        req_valid_in && mode_in == MODE_IO_SHORT |=> ea_addr_out[15:6] == 10'h3ff)
        else $error("io short not in top range");
    a_abs_short_low: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R13
        req_valid_in && mode_in == MODE_ABS_SHORT |=> ea_addr_out[15:6] == 10'h000)
        else $error("abs short not in low range");
    a_acc_imm_form: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R18
        ea_valid_out |-> acc_imm_out[15:0] == 16'h0000
        && acc_imm_out[35:32] == {4{acc_imm_out[31]}}) else $error("accumulator image bad");
endmodule : effective_address_generation

// ===== dv/prog_word_model.sv
`timescale 1ns/100ps
// *****************************************************
// program memory holding extension words
// *****************************************************
module prog_word_model (
    // fetch index from the bench
    input wire logic [3:0] idx_in,
    // extension word handed to the block
    output logic [15:0] word_out
);
    // small word table; unused slots give a changing pattern, never a stale word
    always_comb begin
        case (idx_in)
            4'h0: word_out = 16'h0000;
            4'h1: word_out = 16'hff00; // negative long displacement
            4'h2: word_out = 16'hc002; // absolute long address
            4'h3: word_out = 16'ha987; // negative long immediate
            default: word_out = {4{idx_in}};
        endcase
    end
endmodule : prog_word_model

// ===== dv/effective_address_generation_test.sv
`timescale 1ns/100ps
module effective_address_generation_test;
    import ea_gen_pkg::*;
    // *****************************************************
    // signals
    // *****************************************************
    typedef struct {ea_mode_e m; ptr_sel_e s; logic [15:0] op; logic [3:0] xi;
        logic [15:0] p, o, a, np, imm; logic [1:0] ex;} row_s;
    logic clk_in, rst_n_in, req_valid_in, reg_wr_in, reg_wr_ofs_in, reg_wr_mod_in;
    ea_mode_e mode_in;
    ptr_sel_e ptr_sel_in, reg_wr_sel_in;
    logic [15:0] op_word_in, ext_word_in, reg_wr_data_in, ea_addr_out, imm_data_out;
    logic ea_valid_out, xmem_ref_out, pmem_ref_out, ext_word_used_out, modulo_req_out;
    logic [1:0] extra_cycles_out;
    logic [35:0] acc_imm_out;
    logic [15:0] ptr0_out, ptr1_out, ptr2_out, ptr3_out, sp_out, ofs_out, mod_out;
    logic [3:0] pm_idx;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    // ordinary cases: ex 3 means the cycle count is not checked
    row_s rows [0:14] = '{
        '{MODE_NO_UPDATE, SEL_PTR0, 16'h0, 4'h0, 16'h1234, 16'h0, 16'h1234, 16'h1234, 0, 0},
        '{MODE_POST_INC, SEL_PTR1, 16'h0, 4'h0, 16'hffff, 16'h0, 16'hffff, 16'h0000, 0, 0},
        '{MODE_POST_DEC, SEL_PTR2, 16'h0, 4'h0, 16'h0000, 16'h0, 16'h0000, 16'hffff, 0, 0},
        '{MODE_POST_OFS, SEL_PTR3, 16'h0, 4'h0, 16'h0100, 16'hfff0, 16'h0100, 16'h00f0, 0, 0},
        '{MODE_POST_OFS, SEL_SP, 16'h0, 4'h0, 16'hfffe, 16'h0005, 16'hfffe, 16'h0003, 0, 0},
        '{MODE_INDEX_OFS, SEL_SP, 16'h0, 4'h0, 16'h0200, 16'hfffe, 16'h01fe, 16'h0200, 0, 1},
        '{MODE_SHORT_DISP, SEL_SP, 16'h2, 4'h0, 16'h0400, 16'h0, 16'h03c2, 16'h0400, 0, 1},
        '{MODE_SHORT_DISP, SEL_PTR2, 16'hffd5, 4'h0, 16'h1000, 16'h0, 16'h1015, 16'h1000, 0, 1},
        '{MODE_LONG_DISP, SEL_PTR0, 16'h0, 4'h1, 16'h0050, 16'h0, 16'hff50, 16'h0050, 0, 2},
        '{MODE_ABS_LONG, SEL_PTR0, 16'h0, 4'h2, 16'h0, 16'h0, 16'hc002, 16'h0, 0, 3},
        '{MODE_ABS_SHORT, SEL_PTR0, 16'hffe5, 4'h0, 16'h0, 16'h0, 16'h0025, 16'h0, 0, 0},
        '{MODE_IO_SHORT, SEL_PTR0, 16'h0023, 4'h0, 16'h0, 16'h0, 16'hffe3, 16'h0, 0, 0},
        '{MODE_IMM_LONG, SEL_PTR0, 16'h0, 4'h3, 16'h0, 16'h0, 16'h0, 16'h0, 16'ha987, 1},
        '{MODE_IMM_SHORT_U, SEL_PTR0, 16'h00ff, 4'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h003f, 0},
        '{MODE_IMM_SHORT_S, SEL_PTR0, 16'h0040, 4'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffc0, 0}};
    // *****************************************************
    // instances, clock and timeout
    // *****************************************************
    effective_address_generation effective_address_generation_inst (.clk_in, .rst_n_in,
        .req_valid_in, .mode_in, .ptr_sel_in, .op_word_in, .ext_word_in, .reg_wr_in,
        .reg_wr_sel_in, .reg_wr_ofs_in, .reg_wr_mod_in, .reg_wr_data_in, .ea_valid_out,
        .ea_addr_out, .xmem_ref_out, .pmem_ref_out, .ext_word_used_out, .extra_cycles_out,
        .imm_data_out, .acc_imm_out, .modulo_req_out, .ptr0_out, .ptr1_out, .ptr2_out,
        .ptr3_out, .sp_out, .ofs_out, .mod_out);
    prog_word_model prog_word_model_inst (.idx_in(pm_idx), .word_out(ext_word_in));
    // free running clock
    always #4 clk_in = ~clk_in;
    // hang guard
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            summarize();
        end
    end
    // *****************************************************
    // tasks
    // *****************************************************
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one core register write: offset, modifier or pointer
    task automatic wr(input logic o, input logic md, input ptr_sel_e s, input logic [15:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_wr_ofs_in <= o;
        reg_wr_mod_in <= md;
        reg_wr_sel_in <= s;
        reg_wr_data_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask : wr
    // one request, results sampled just after the answering edge
    task automatic req(input ea_mode_e m, input ptr_sel_e s, input logic [15:0] op,
        input logic [3:0] xi);
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        mode_in <= m;
        ptr_sel_in <= s;
        op_word_in <= op;
        pm_idx <= xi;
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        #1;
    endtask : req
    function automatic logic [15:0] pv(input ptr_sel_e s);
        case (s)
            SEL_PTR0: pv = ptr0_out;
            SEL_PTR1: pv = ptr1_out;
            SEL_PTR2: pv = ptr2_out;
            SEL_PTR3: pv = ptr3_out;
            default: pv = sp_out;
        endcase
    endfunction : pv
    task automatic summarize();
        if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    // *****************************************************
    // main sequence
    // *****************************************************
    initial begin
        logic im;
        {clk_in, rst_n_in, req_valid_in, reg_wr_in, reg_wr_ofs_in, reg_wr_mod_in} = '0;
        {op_word_in, reg_wr_data_in, pm_idx} = '0;
        mode_in = MODE_NO_UPDATE;
        ptr_sel_in = SEL_PTR0;
        reg_wr_sel_in = SEL_PTR0;
        repeat (4) @(posedge clk_in);
        check(mod_out, 16'hffff);
        check(ptr0_out, 16'h0000);
        rst_n_in <= 1'b1;
        // table of ordinary cases
        foreach (rows[i]) begin
            im = rows[i].m inside {MODE_IMM_LONG, MODE_IMM_SHORT_U, MODE_IMM_SHORT_S};
            wr(1'b1, 1'b0, rows[i].s, rows[i].o);
            wr(1'b0, 1'b0, rows[i].s, rows[i].p);
            req(rows[i].m, rows[i].s, rows[i].op, rows[i].xi);
            check(ea_valid_out, 1'b1);
            check(ea_addr_out, rows[i].a);
            check(pv(rows[i].s), rows[i].np);
            check(ofs_out, rows[i].o);
            if (rows[i].ex != 2'h3) check(extra_cycles_out, rows[i].ex);
            check(ext_word_used_out, rows[i].xi != 4'h0);
            check(pmem_ref_out, im || rows[i].m == MODE_ABS_LONG);
            check(xmem_ref_out, !im);
            check(modulo_req_out, 1'b0);
            if (im) check(imm_data_out, rows[i].imm);
            if (rows[i].m == MODE_IMM_LONG) check(acc_imm_out, {4'hf, 16'ha987, 16'h0});
        end
        // two post-increments, one idle cycle apart, across the sign boundary
        wr(1'b0, 1'b0, SEL_PTR3, 16'h7fff);
        req(MODE_POST_INC, SEL_PTR3, 16'h0, 4'h0);
        req(MODE_POST_INC, SEL_PTR3, 16'h0, 4'h0);
        check(ea_addr_out, 16'h8000);
        check(ptr3_out, 16'h8001);
        @(posedge clk_in);
        #1;
        check(ea_valid_out, 1'b0);
        // modifier away from linear: only pointers zero and one flag modulo
        wr(1'b0, 1'b1, SEL_PTR0, 16'h0003);
        check(mod_out, 16'h0003);
        req(MODE_POST_INC, SEL_PTR0, 16'h0, 4'h0);
        check(modulo_req_out, 1'b1);
        req(MODE_POST_DEC, SEL_PTR1, 16'h0, 4'h0);
        check(modulo_req_out, 1'b1);
        req(MODE_POST_INC, SEL_PTR2, 16'h0, 4'h0);
        check(modulo_req_out, 1'b0);
        req(MODE_INDEX_OFS, SEL_PTR1, 16'h0, 4'h0);
        check(modulo_req_out, 1'b1);
        req(MODE_POST_INC, SEL_SP, 16'h0, 4'h0);
        check(modulo_req_out, 1'b0);
        req(MODE_SHORT_DISP, SEL_PTR2, 16'h0001, 4'h0);
        check(modulo_req_out, 1'b0);
        req(MODE_NO_UPDATE, SEL_PTR0, 16'h0, 4'h0);
        check(modulo_req_out, 1'b0);
        // second reset in mid-run
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        #1;
        check(mod_out, 16'hffff);
        check(ptr3_out, 16'h0000);
        check(ea_valid_out, 1'b0);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        // first request after the second release
        req(MODE_POST_INC, SEL_SP, 16'h0, 4'h0);
        check(ea_addr_out, 16'h0000);
        check(sp_out, 16'h0001);
        check(mod_out, 16'hffff);
        summarize();
    end
endmodule : effective_address_generation_test
